// ==== common/pisr_pkg.sv ====
// register map, field positions and reset values of the status/mask bank
// assumes: byte-wide register port, one clock domain
package pisr_pkg;
   localparam logic [7:0] OFS_EVT_TOP = 8'h18;
   localparam logic [7:0] OFS_EVT_LOW = 8'h19;
   localparam logic [7:0] OFS_EVT_UP = 8'h1A;
   localparam logic [7:0] OFS_THERM_RAW = 8'h1B;
   localparam logic [7:0] OFS_UP_STAT = 8'h1D;
   localparam logic [7:0] OFS_GLB_MASK = 8'h1E;
   localparam logic [7:0] OFS_LOW_MASK = 8'h1F;
   localparam logic [7:0] OFS_UP_MASK = 8'h20;
   // per-core nibble layout, upper core of a pair sits 4 bits higher
   localparam int BIT_ILIM = 0;
   localparam int BIT_SC = 1;
   localparam int BIT_PG = 2;
   localparam int BIT_ON = 3;
   localparam int NIB_HI = 4;
   // global bits
   localparam int BIT_LDRDY = 0;
   localparam int BIT_RSTREG = 1;
   localparam int BIT_TWARN = 2;
   localparam int BIT_TSD = 3;
   // reset values and writable bits
   localparam logic [7:0] GLB_MASK_RST = 8'h02;
   localparam logic [7:0] GLB_MASK_RW = 8'h07;
   localparam logic [7:0] CORE_MASK_RST = 8'h55;
   localparam logic [7:0] CORE_MASK_RW = 8'h55;
   localparam logic [7:0] CORE_FLAG_BITS = 8'h77;
   localparam logic [7:0] TOP_FLAG_BITS = 8'h07;
   localparam logic [7:0] REG_ZERO = 8'h00;
   localparam logic [15:0] SYNC_RST = 16'h0000;
   // synchroniser vector layout
   localparam int SY_ILIM = 0;
   localparam int SY_SHORT = 4;
   localparam int SY_PGLOW = 8;
   localparam int SY_ON2 = 12;
   localparam int SY_ON3 = 13;
   localparam int SY_TWARN = 14;
   localparam int SY_TSD = 15;
endpackage : pisr_pkg

// ==== hw/pisr_bank.sv ====
// status, latched event flags and interrupt masks of a four-core converter
// assumes: register port is the decoded output of the serial interface,
// same clock; analog condition pins are asynchronous and synchronised here
//
// Functional notes
// RL1: core 3 on-state at bit 7, core 2 at bit 3, status register, read-only.
// RL2: raw power-good per core, 1 while output below threshold, bits 6 and 2.
// RL3: raw current-limit per core, 1 while limiting active, bits 4 and 0.
// RL4: core 2/3 status fully read-only, reserved bits 5 and 1 read zero, zero after reset.
// RL5: thermal warning mask bit 2 resets 0; 0 lets warning interrupt, 1 blocks.
// RL6: thermal warning mask never changes raw thermal warning status.
// RL7: register-reset mask bit 1 resets 1; writing 0 allows that interrupt.
// RL8: load-measurement-ready mask bit 0 resets 0; 1 suppresses that interrupt.
// RL9: core 1/0 power-good masks at bits 6/2, reset 1, 0 enables interrupt.
// RL10: core 1/0 current-limit masks at bits 4/0, reset 1, 0 enables interrupt.
// RL11: per-core masks gate interrupts only, raw status stays live.
// RL12: latched event flags hold until software writes 1 to their bit.
// RL13: raw thermal register shows shutdown at bit 3 and warning at bit 2.
// RL14: interrupt asserted while any flag set with mask 0, else deasserted.
`timescale 1ns/1ns
`default_nettype none
module pisr_bank
   import pisr_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic ce,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [3:0] core_curlimit_pin,
   input wire logic [3:0] core_short_pin,
   input wire logic [3:0] core_power_low_pin,
   input wire logic core2_on_pin,
   input wire logic core3_on_pin,
   input wire logic thermal_warn_pin,
   input wire logic thermal_shutdown_pin,
   input wire logic reg_reset_event,
   input wire logic load_ready_event,
   output logic irq_out
);

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
      hit = (addr == ofs);
   endfunction : hit

   logic [15:0] sync1;
   logic [15:0] sync2;
   logic [15:0] prev;
   logic [7:0] flag_top;
   logic [15:0] flag_core;
   logic [7:0] mask_glb;
   logic [15:0] mask_core;
   logic [15:0] set_core;
   logic [7:0] set_top;
   logic [15:0] clr_core;
   logic [7:0] clr_top;
   logic [15:0] next_flag_core;
   logic [7:0] next_flag_top;
   logic [7:0] up_status;
   logic [7:0] therm_raw;
   logic [7:0] next_rdata;
   logic pending;
   logic core3_on_flag;
   logic core2_on_flag;
   logic core3_power_ok_raw;
   logic core2_power_ok_raw;
   logic core3_curlimit_raw;
   logic core2_curlimit_raw;
   logic thermal_warn_raw;
   logic thermal_shutdown_raw;
   logic thermal_warn_irq_block;

   // two-stage synchroniser; only the second stage feeds logic
   // prev keeps last cycle's synchronised levels for edge detection; its on and shutdown bits go unused
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         sync1 <= SYNC_RST;
         sync2 <= SYNC_RST;
         prev <= SYNC_RST;
      end else if (ce) begin
         sync1 <= {thermal_shutdown_pin, thermal_warn_pin, core3_on_pin, core2_on_pin,
                   core_power_low_pin, core_short_pin, core_curlimit_pin};
         sync2 <= sync1;
         prev <= sync2;
      end
   end

   assign core3_on_flag = sync2[SY_ON3];
   assign core2_on_flag = sync2[SY_ON2];
   assign core3_power_ok_raw = sync2[SY_PGLOW + 3];
   assign core2_power_ok_raw = sync2[SY_PGLOW + 2];
   assign core3_curlimit_raw = sync2[SY_ILIM + 3];
   assign core2_curlimit_raw = sync2[SY_ILIM + 2];
   assign thermal_warn_raw = sync2[SY_TWARN];
   assign thermal_shutdown_raw = sync2[SY_TSD];
   assign thermal_warn_irq_block = mask_glb[BIT_TWARN];

   // raw status comes from the synchronised pins, masks never enter this path
   always_comb begin
      up_status = REG_ZERO; // RL4 RL11
      up_status[NIB_HI + BIT_ON] = core3_on_flag; // RL1
      up_status[BIT_ON] = core2_on_flag; // RL1
      up_status[NIB_HI + BIT_PG] = core3_power_ok_raw; // RL2
      up_status[BIT_PG] = core2_power_ok_raw; // RL2
      up_status[NIB_HI + BIT_ILIM] = core3_curlimit_raw; // RL3
      up_status[BIT_ILIM] = core2_curlimit_raw; // RL3
      therm_raw = REG_ZERO;
      therm_raw[BIT_TSD] = thermal_shutdown_raw; // RL13
      therm_raw[BIT_TWARN] = thermal_warn_raw; // RL6
   end

   // per-core events: rising current limit, rising short, any power-good change
   genvar c;
   generate
      for (c = 0; c < 4; c++) begin : g_core
         assign set_core[c*4 + BIT_ILIM] = sync2[SY_ILIM + c] & ~prev[SY_ILIM + c];
         assign set_core[c*4 + BIT_SC] = sync2[SY_SHORT + c] & ~prev[SY_SHORT + c];
         assign set_core[c*4 + BIT_PG] = sync2[SY_PGLOW + c] ^ prev[SY_PGLOW + c];
         assign set_core[c*4 + BIT_ON] = 1'b0;
      end
   endgenerate

   always_comb begin
      set_top = REG_ZERO;
      set_top[BIT_TWARN] = thermal_warn_raw & ~prev[SY_TWARN];
      set_top[BIT_RSTREG] = reg_reset_event;
      set_top[BIT_LDRDY] = load_ready_event;
      clr_top = (reg_wr && hit(reg_addr, OFS_EVT_TOP)) ? reg_wdata : REG_ZERO;
      clr_core[7:0] = (reg_wr && hit(reg_addr, OFS_EVT_LOW)) ? reg_wdata : REG_ZERO;
      clr_core[15:8] = (reg_wr && hit(reg_addr, OFS_EVT_UP)) ? reg_wdata : REG_ZERO;
      // a new event in the clearing cycle survives the clear
      next_flag_top = ((flag_top & ~clr_top) | set_top) & TOP_FLAG_BITS; // RL12
      next_flag_core = ((flag_core & ~clr_core) | set_core) & {CORE_FLAG_BITS, CORE_FLAG_BITS}; // RL12
   end

   // event pulses are same-clock and go straight in; pin events arrive two cycles late
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         flag_top <= REG_ZERO;
         flag_core <= {REG_ZERO, REG_ZERO};
      end else if (ce) begin
         flag_top <= next_flag_top; // RL12
         flag_core <= next_flag_core; // RL12
      end
   end

   // reserved mask bits are dropped on write so they always read back zero
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         mask_glb <= GLB_MASK_RST; // RL5 RL7 RL8
         mask_core <= {CORE_MASK_RST, CORE_MASK_RST}; // RL9 RL10
      end else if (ce && reg_wr) begin
         if (hit(reg_addr, OFS_GLB_MASK)) begin
            mask_glb <= reg_wdata & GLB_MASK_RW;
         end
         if (hit(reg_addr, OFS_LOW_MASK)) begin
            mask_core[7:0] <= reg_wdata & CORE_MASK_RW;
         end
         if (hit(reg_addr, OFS_UP_MASK)) begin
            mask_core[15:8] <= reg_wdata & CORE_MASK_RW;
         end
      end
   end

   // short-circuit flags have no mask bit, their mask position is held at zero
   // a masked flag stays latched, so lifting its mask later raises the interrupt at once
   assign pending = (|(flag_top & ~mask_glb)) | (|(flag_core & ~mask_core)); // RL14

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         irq_out <= 1'b0;
      end else if (ce) begin
         irq_out <= pending; // RL14
      end
   end

   // writes to flag registers clear the bits written as 1; raw status registers have no storage here, so writes to them are simply lost
   always_comb begin
      case (reg_addr)
         OFS_EVT_TOP: next_rdata = flag_top;
         OFS_EVT_LOW: next_rdata = flag_core[7:0];
         OFS_EVT_UP: next_rdata = flag_core[15:8];
         OFS_THERM_RAW: next_rdata = therm_raw; // RL13
         OFS_UP_STAT: next_rdata = up_status; // RL4
         OFS_GLB_MASK: next_rdata = mask_glb;
         OFS_LOW_MASK: next_rdata = mask_core[7:0];
         OFS_UP_MASK: next_rdata = mask_core[15:8];
         default: next_rdata = REG_ZERO;
      endcase
   end

   // read data is held between reads so a slow serial shifter can take it
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         reg_rdata <= REG_ZERO;
      end else if (ce && reg_rd) begin
         reg_rdata <= next_rdata;
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   sequence s_read(logic [7:0] ofs);
      ce && reg_rd && reg_addr == ofs;
   endsequence

   sequence s_clear_low0;
      ce && reg_wr && reg_addr == OFS_EVT_LOW && reg_wdata[BIT_ILIM];
   endsequence

   sequence s_no_new_ilim0;
      !set_core[BIT_ILIM];
   endsequence

   sequence s_write(logic [7:0] ofs);
      ce && reg_wr && reg_addr == ofs;
   endsequence

   sequence s_clear_ldrdy;
      ce && reg_wr && reg_addr == OFS_EVT_TOP && reg_wdata[BIT_LDRDY];
   endsequence

   a_on_flag_read: assert property (s_read(OFS_UP_STAT) |=> // RL1
      reg_rdata[7] == $past(sync2[SY_ON3]) && reg_rdata[3] == $past(sync2[SY_ON2]))
      else $error("core on-state read back wrong");
   a_power_raw_read: assert property (s_read(OFS_UP_STAT) |=> // RL2
      reg_rdata[6] == $past(sync2[SY_PGLOW + 3]) && reg_rdata[2] == $past(sync2[SY_PGLOW + 2]))
      else $error("power-good raw read back wrong");
   a_limit_raw_read: assert property (s_read(OFS_UP_STAT) |=> // RL3
      reg_rdata[4] == $past(sync2[SY_ILIM + 3]) && reg_rdata[0] == $past(sync2[SY_ILIM + 2]))
      else $error("current-limit raw read back wrong");
   a_stat_reserved_zero: assert property (s_read(OFS_UP_STAT) |=> !reg_rdata[5] && !reg_rdata[1]) // RL4
      else $error("status reserved bit not zero");
   a_twarn_irq_pass: assert property (ce && flag_top[BIT_TWARN] && !thermal_warn_irq_block |=> irq_out) // RL5
      else $error("unmasked thermal warning gave no interrupt");
   a_twarn_raw_live: assert property (s_read(OFS_THERM_RAW) ##0 thermal_warn_irq_block // RL6
      |=> reg_rdata[BIT_TWARN] == $past(sync2[SY_TWARN]))
      else $error("thermal warning raw not live");
   a_rstreg_blocked: assert property (ce && flag_top == 8'h02 && flag_core == 16'h0000 // RL7
      && mask_glb[BIT_RSTREG] |=> !irq_out)
      else $error("masked register reset raised interrupt");
   a_ldrdy_irq_pass: assert property (ce && flag_top[BIT_LDRDY] && !mask_glb[BIT_LDRDY] |=> irq_out) // RL8
      else $error("unmasked measurement ready gave no interrupt");
   a_core1_pg_pass: assert property (ce && flag_core[NIB_HI + BIT_PG] && !mask_core[NIB_HI + BIT_PG] |=> irq_out) // RL9
      else $error("unmasked core 1 power-good gave no interrupt");
   a_core0_ilim_pass: assert property (ce && flag_core[BIT_ILIM] && !mask_core[BIT_ILIM] |=> irq_out) // RL10
      else $error("unmasked core 0 current limit gave no interrupt");
   a_mask_not_raw: assert property (s_read(OFS_UP_STAT) ##0 !mask_core[8 + BIT_ILIM] // RL11
      |=> reg_rdata[0] == $past(sync2[SY_ILIM + 2]))
      else $error("mask write disturbed raw status");
   a_flag_holds: assert property (ce && flag_core[BIT_ILIM] && !(reg_wr && reg_addr == OFS_EVT_LOW) // RL12
      |=> flag_core[BIT_ILIM])
      else $error("latched flag dropped without clear");
   a_flag_clears: assert property (s_clear_low0 and s_no_new_ilim0 |=> !flag_core[BIT_ILIM]) // RL12
      else $error("write one did not clear flag");
   a_tsd_raw_read: assert property (s_read(OFS_THERM_RAW) |=> reg_rdata[BIT_TSD] == $past(sync2[SY_TSD])) // RL13
      else $error("thermal shutdown raw read back wrong");
   a_irq_quiet: assert property (ce && !pending |=> !irq_out) // RL14
      else $error("interrupt with nothing pending");
   // mask storage, blocked sources, event capture, set against clear and the clock enable
   a_glb_mask_write: assert property (s_write(OFS_GLB_MASK) // RL5 RL7 RL8
      |=> mask_glb == ($past(reg_wdata) & GLB_MASK_RW))
      else $error("global mask write not stored");
   a_low_mask_write: assert property (s_write(OFS_LOW_MASK) // RL9 RL10
      |=> mask_core[7:0] == ($past(reg_wdata) & CORE_MASK_RW))
      else $error("core 0/1 mask write not stored");
   a_up_mask_write: assert property (s_write(OFS_UP_MASK)
      |=> mask_core[15:8] == ($past(reg_wdata) & CORE_MASK_RW))
      else $error("core 2/3 mask write not stored");
   a_rstreg_irq_pass: assert property (ce && flag_top[BIT_RSTREG] && !mask_glb[BIT_RSTREG] |=> irq_out) // RL7
      else $error("unmasked register reset gave no interrupt");
   a_ldrdy_blocked: assert property (ce && flag_top == 8'h01 && flag_core == 16'h0000 // RL8
      && mask_glb[BIT_LDRDY] |=> !irq_out)
      else $error("masked measurement ready raised interrupt");
   a_core0_ilim_blocked: assert property (ce && flag_core == 16'h0001 && flag_top == 8'h00 // RL10
      && mask_core[BIT_ILIM] |=> !irq_out)
      else $error("masked core 0 current limit raised interrupt");
   a_core1_pg_blocked: assert property (ce && flag_core == 16'h0041 && flag_top == 8'h00 // RL9
      && mask_core[NIB_HI + BIT_PG] && mask_core[BIT_ILIM] |=> !irq_out)
      else $error("masked core 1 power-good raised interrupt");
   a_pg_any_change: assert property (ce && sync2[SY_PGLOW + 1] != prev[SY_PGLOW + 1] // RL12
      |=> flag_core[NIB_HI + BIT_PG])
      else $error("power-good change did not set flag");
   a_twarn_rise_flag: assert property (ce && thermal_warn_raw && !prev[SY_TWARN] // RL12
      |=> flag_top[BIT_TWARN])
      else $error("thermal warning rise did not set flag");
   a_ldrdy_set: assert property (ce && load_ready_event |=> flag_top[BIT_LDRDY]) // RL12
      else $error("measurement ready pulse did not set flag");
   a_set_wins_clear: assert property (s_clear_ldrdy ##0 load_ready_event |=> flag_top[BIT_LDRDY]) // RL12
      else $error("clear beat a new event");
   a_short_unmasked: assert property (ce && (flag_core[8 + BIT_SC] || flag_core[12 + BIT_SC]) |=> irq_out) // RL14
      else $error("short-circuit flag gave no interrupt");
   a_ce_freeze: assert property (!ce |=> $stable(flag_top) && $stable(flag_core) && $stable(mask_glb)
      && $stable(mask_core) && $stable(irq_out) && $stable(reg_rdata))
      else $error("state moved while clock enable low");
   a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");

endmodule : pisr_bank
`default_nettype wire

// ==== tb/pisr_bank_test.sv ====
// self-checking bench for the status/mask bank: raw status, masks, flags, irq
// assumes: pisr_pkg compiled first; all inputs driven on the falling edge
`timescale 1ns/1ns
`default_nettype none
module pisr_bank_test;
   import pisr_pkg::*;
   logic ref_clk = 1'h0;
   logic reset = 1'h1;
   logic ce = 1'h1;
   logic [7:0] reg_addr = 8'h00;
   logic reg_wr = 1'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_rd = 1'h0;
   logic [7:0] reg_rdata;
   logic [3:0] core_curlimit_pin = 4'h0;
   logic [3:0] core_short_pin = 4'h0;
   logic [3:0] core_power_low_pin = 4'h0;
   logic core2_on_pin = 1'h0;
   logic core3_on_pin = 1'h0;
   logic thermal_warn_pin = 1'h0;
   logic thermal_shutdown_pin = 1'h0;
   logic reg_reset_event = 1'h0;
   logic load_ready_event = 1'h0;
   logic irq_out;
   int n_fail = 0;
   int n_compared = 0;
   always #25 ref_clk = ~ref_clk;
   pisr_bank pisr_bank_i (.ref_clk(ref_clk), .reset(reset), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_curlimit_pin(core_curlimit_pin),
      .core_short_pin(core_short_pin), .core_power_low_pin(core_power_low_pin), .core2_on_pin(core2_on_pin),
      .core3_on_pin(core3_on_pin), .thermal_warn_pin(thermal_warn_pin),
      .thermal_shutdown_pin(thermal_shutdown_pin), .reg_reset_event(reg_reset_event),
      .load_ready_event(load_ready_event), .irq_out(irq_out));
   task automatic stop_test();
      $display("compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : stop_test
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'h1;
      @(negedge ref_clk);
      reg_wr = 1'h0;
   endtask : wr
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk8
   task automatic chk1(input logic exp, input string what);
      n_compared++;
      if (irq_out !== exp) begin
         n_fail++;
         $display("ERROR %0t: irq %s got %b expected %b", $time, what, irq_out, exp);
      end
   endtask : chk1
   task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(negedge ref_clk);
      reg_addr = a;
      reg_rd = 1'h1;
      @(negedge ref_clk);
      reg_rd = 1'h0;
      chk8(reg_rdata, exp, what);
   endtask : chk_reg
   // pulse is sampled at one rising edge only
   task automatic pulse_load();
      @(negedge ref_clk);
      load_ready_event = 1'h1;
      @(negedge ref_clk);
      load_ready_event = 1'h0;
   endtask : pulse_load
   // one status byte drives the pins behind it; reserved positions drive the short pins
   task automatic drive_stat(input logic [7:0] v);
      {core3_on_pin, core_power_low_pin[3], core_short_pin[3], core_curlimit_pin[3]} = v[7:4];
      {core2_on_pin, core_power_low_pin[2], core_short_pin[2], core_curlimit_pin[2]} = v[3:0];
   endtask : drive_stat
   // pg flags also set on falling edges, so clear only after pins have settled
   task automatic clr_all();
      cyc(4);
      wr(OFS_EVT_TOP, 8'hFF);
      wr(OFS_EVT_LOW, 8'hFF);
      wr(OFS_EVT_UP, 8'hFF);
      cyc(1);
      chk1(1'h0, "after clear");
   endtask : clr_all
   task automatic t_reset();
      chk1(1'h0, "reset");
      chk_reg(OFS_UP_STAT, 8'h00, "status reset");
      chk_reg(OFS_GLB_MASK, 8'h02, "global mask reset");
      chk_reg(OFS_LOW_MASK, 8'h55, "core mask reset");
      chk_reg(8'h30, 8'h00, "unmapped");
   endtask : t_reset
   task automatic t_status();
      for (int i = 0; i < 8; i++) begin
         drive_stat(8'h01 << i);
         cyc(3);
         chk_reg(OFS_UP_STAT, (8'h01 << i) & 8'hDD, "status bit");
      end
      drive_stat(8'hFF);
      wr(OFS_UP_MASK, 8'h00);
      wr(OFS_UP_STAT, 8'h00);
      cyc(3);
      chk_reg(OFS_UP_STAT, 8'hDD, "status under write");
      wr(OFS_UP_MASK, 8'h55);
      drive_stat(8'h00);
      clr_all();
   endtask : t_status
   task automatic t_mask_rw();
      wr(OFS_GLB_MASK, 8'hFF);
      chk_reg(OFS_GLB_MASK, 8'h07, "global mask bits");
      wr(OFS_LOW_MASK, 8'hFF);
      chk_reg(OFS_LOW_MASK, 8'h55, "core mask bits");
      wr(OFS_LOW_MASK, 8'h00);
      chk_reg(OFS_LOW_MASK, 8'h00, "core mask clear");
      wr(OFS_LOW_MASK, 8'h55);
      wr(OFS_GLB_MASK, 8'h02);
   endtask : t_mask_rw
   task automatic t_thermal();
      wr(OFS_GLB_MASK, 8'h07);
      thermal_warn_pin = 1'h1;
      thermal_shutdown_pin = 1'h1;
      cyc(4);
      chk_reg(OFS_THERM_RAW, 8'h0C, "raw thermal masked");
      chk1(1'h0, "warn masked");
      wr(OFS_GLB_MASK, 8'h03);
      cyc(1);
      chk1(1'h1, "warn unmasked");
      thermal_warn_pin = 1'h0;
      thermal_shutdown_pin = 1'h0;
      wr(OFS_GLB_MASK, 8'h02);
      clr_all();
   endtask : t_thermal
   task automatic t_load();
      @(negedge ref_clk);
      load_ready_event = 1'h1;
      @(negedge ref_clk);
      load_ready_event = 1'h0;
      chk1(1'h0, "load one edge");
      cyc(1);
      chk1(1'h1, "load ready");
      cyc(5);
      chk1(1'h1, "load held");
      wr(OFS_EVT_TOP, 8'h01);
      cyc(1);
      chk1(1'h0, "load cleared");
      wr(OFS_GLB_MASK, 8'h03);
      pulse_load();
      cyc(2);
      chk1(1'h0, "load masked");
      chk_reg(OFS_EVT_TOP, 8'h01, "load flag");
      wr(OFS_GLB_MASK, 8'h02);
      clr_all();
   endtask : t_load
   task automatic t_regreset();
      @(negedge ref_clk);
      reg_reset_event = 1'h1;
      @(negedge ref_clk);
      reg_reset_event = 1'h0;
      cyc(2);
      chk1(1'h0, "reg reset default");
      chk_reg(OFS_EVT_TOP, 8'h02, "reg reset flag");
      wr(OFS_GLB_MASK, 8'h00);
      cyc(1);
      chk1(1'h1, "reg reset unmasked");
      wr(OFS_GLB_MASK, 8'h02);
      clr_all();
   endtask : t_regreset
   task automatic t_core01();
      wr(OFS_LOW_MASK, 8'h54);
      core_curlimit_pin[0] = 1'h1;
      cyc(4);
      chk1(1'h1, "core0 limit");
      wr(OFS_LOW_MASK, 8'h55);
      cyc(1);
      chk1(1'h0, "core0 masked");
      chk_reg(OFS_EVT_LOW, 8'h01, "core0 flag");
      wr(OFS_LOW_MASK, 8'h15);
      core_power_low_pin[1] = 1'h1;
      cyc(4);
      chk1(1'h1, "core1 power");
      chk_reg(OFS_EVT_LOW, 8'h41, "core1 flag");
      wr(OFS_LOW_MASK, 8'h55);
      core_curlimit_pin[0] = 1'h0;
      core_power_low_pin[1] = 1'h0;
      clr_all();
   endtask : t_core01
   // a clear and a new event in one cycle must leave the flag set
   task automatic t_collide();
      @(negedge ref_clk);
      reg_addr = OFS_EVT_TOP;
      reg_wdata = 8'h01;
      reg_wr = 1'h1;
      load_ready_event = 1'h1;
      @(negedge ref_clk);
      reg_wr = 1'h0;
      load_ready_event = 1'h0;
      chk_reg(OFS_EVT_TOP, 8'h01, "set beats clear");
      chk1(1'h1, "set beats clear irq");
      clr_all();
   endtask : t_collide
   // with the clock enable low nothing may move, not an event pulse nor a write
   task automatic t_freeze();
      @(negedge ref_clk);
      ce = 1'h0;
      load_ready_event = 1'h1;
      reg_addr = OFS_GLB_MASK;
      reg_wdata = 8'h07;
      reg_wr = 1'h1;
      @(negedge ref_clk);
      load_ready_event = 1'h0;
      reg_wr = 1'h0;
      cyc(1);
      ce = 1'h1;
      chk1(1'h0, "frozen event");
      chk_reg(OFS_EVT_TOP, 8'h00, "frozen flag");
      chk_reg(OFS_GLB_MASK, 8'h02, "frozen mask");
   endtask : t_freeze
   initial begin
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      reset = 1'h0;
      t_reset();
      t_status();
      t_mask_rw();
      t_thermal();
      t_load();
      t_regreset();
      t_core01();
      t_collide();
      t_freeze();
      stop_test();
   end
   // the sequence needs well under 500 cycles
   initial begin
      #(50 * 3000);
      n_fail++;
      stop_test();
   end
endmodule : pisr_bank_test
`default_nettype wire
